// >>> verilog/iem_pkg.sv
// constants shared by the interrupt enable mask block
package iem_pkg;
  localparam int          DATA_W           = 32;
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  OFF_ENABLE_SET   = 8'h88;
  localparam logic [7:0]  OFF_ENABLE_CLEAR = 8'h8C;
  localparam logic [7:0]  OFF_EVENT_FLAGS  = 8'h80;
  localparam logic [7:0]  OFF_EVENT_MASKED = 8'h84;
  localparam int          GATE_BIT         = 31;
  localparam int          MAKER_BIT        = 30;
  localparam int          SOFT_BIT         = 29;
  localparam logic [31:0] MASK_WRITABLE    = 32'hEFFF_83FF;
  localparam logic [31:0] MASK_RESET       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// >>> verilog/iem_mask_reg.sv
// the interrupt enable mask register with set and clear ports
module iem_mask_reg (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        set_we,
  input  wire logic        clr_we,
  input  wire logic [31:0] wdata,
  output logic      [31:0] mask
);
  logic [31:0] mask_ff;
  logic [31:0] nxt_mask;

  always_comb begin
    nxt_mask = mask_ff;
    if (set_we) begin
      nxt_mask = nxt_mask | wdata;
    end
    if (clr_we) begin
      nxt_mask = nxt_mask & ~wdata;
    end
    nxt_mask = nxt_mask & iem_pkg::MASK_WRITABLE;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff <= iem_pkg::MASK_RESET;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  assign mask = mask_ff;

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (mask_ff & ~iem_pkg::MASK_WRITABLE) == 32'h0000_0000)
    else $error("reserved mask bits nonzero");
  chk_reserved_low: assert property (@(posedge clk) disable iff (rst)
    mask_ff[14:10] == 5'h00)
    else $error("mask bits 14:10 nonzero");
  chk_set_takes: assert property (@(posedge clk) disable iff (rst)
    set_we && !clr_we |=>
      ((mask_ff & $past(wdata) & iem_pkg::MASK_WRITABLE) == ($past(wdata) & iem_pkg::MASK_WRITABLE)))
    else $error("set did not set mask bits");
  chk_clear_takes: assert property (@(posedge clk) disable iff (rst)
    clr_we |=> ((mask_ff & $past(wdata)) == 32'h0000_0000))
    else $error("clear did not clear mask bits");
  chk_zero_hold: assert property (@(posedge clk) disable iff (rst)
    !set_we && !clr_we |=> mask_ff == $past(mask_ff))
    else $error("mask changed without write");
endmodule

// >>> verilog/iem_gate.sv
// gates event flags by the mask and the global gate
module iem_gate (
  input  wire logic [31:0] events,
  input  wire logic [31:0] mask,
  output logic             irq_req
);
  logic [30:0] hits;
  always_comb begin
    hits    = events[30:0] & mask[30:0];
    irq_req = mask[iem_pkg::GATE_BIT] & (|hits);
  end
endmodule

// >>> verilog/iem_top.sv
// interrupt enable mask with axi4-lite register access
// Overview of operation
// - Reading the set or the clear address returns the one mask register.
// - A one written at the set address sets that bit, at the clear address clears it, zeros leave it.
// - Each mask bit except the global gate lines up with the event bit it gates.
// - With the global gate set, interrupts follow the per-event mask bits.
// - With the global gate clear, no interrupt is raised at all.
// - The global gate does not change what a read of the masked event address returns.
// - Mask bit 30 lets the maker defined event at bit 30 interrupt.
// - Mask bit 29 lets the software raised event at bit 29 interrupt.
// - Mask bit 28 always reads zero.
// - Mask bits 14 to 10 always read zero.
// - Mask bits 27 to 15 pass or block their events.
// - Mask bits 9 to 0 pass their events when set.
module iem_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic [31:0] EVENT_FLAGS,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             IRQ_OUT
);
  logic        aw_got_ff;
  logic        nxt_aw_got;
  logic [7:0]  awaddr_ff;
  logic [7:0]  nxt_awaddr;
  logic        w_got_ff;
  logic        nxt_w_got;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic        bvalid_ff;
  logic        nxt_bvalid;
  logic [1:0]  bresp_ff;
  logic [1:0]  nxt_bresp;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0]  rresp_ff;
  logic [1:0]  nxt_rresp;
  logic        awready_ff;
  logic        nxt_awready;
  logic        wready_ff;
  logic        nxt_wready;
  logic        arready_ff;
  logic        nxt_arready;
  logic        irq_ff;
  logic        set_we;
  logic        clr_we;
  logic        do_write;
  logic [31:0] be_data;
  logic [31:0] mask;
  logic        irq_req;

  function automatic logic [31:0] strb_expand(input logic [3:0] s);
    strb_expand = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // write side: address and data taken in any order
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_got  = w_got_ff;
    nxt_wdata  = wdata_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    do_write   = 1'b0;
    if (S_AXI_AWVALID && !aw_got_ff) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_got_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = S_AXI_WDATA & strb_expand(S_AXI_WSTRB);
    end
    if (aw_got_ff && w_got_ff && !bvalid_ff) begin
      do_write   = 1'b1;
      nxt_bvalid = 1'b1;
      nxt_bresp  = (awaddr_ff == iem_pkg::OFF_ENABLE_SET || awaddr_ff == iem_pkg::OFF_ENABLE_CLEAR)
                   ? iem_pkg::RESP_OKAY : iem_pkg::RESP_SLVERR;
    end
    if (bvalid_ff && S_AXI_BREADY) begin
      nxt_bvalid = 1'b0;
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
    end
    nxt_awready = !nxt_aw_got;
    nxt_wready  = !nxt_w_got;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      w_got_ff  <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
    end else begin
      aw_got_ff <= nxt_aw_got;
      awaddr_ff <= nxt_awaddr;
      w_got_ff  <= nxt_w_got;
      wdata_ff  <= nxt_wdata;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
    end
  end

  assign be_data = wdata_ff;
  assign set_we  = do_write && (awaddr_ff == iem_pkg::OFF_ENABLE_SET);
  assign clr_we  = do_write && (awaddr_ff == iem_pkg::OFF_ENABLE_CLEAR);

  iem_mask_reg u_mask (
    .clk    (SYS_CLK),
    .rst    (RESET),
    .set_we (set_we),
    .clr_we (clr_we),
    .wdata  (be_data),
    .mask   (mask)
  );

  iem_gate u_gate (
    .events  (EVENT_FLAGS),
    .mask    (mask),
    .irq_req (irq_req)
  );

  // read side
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && S_AXI_RREADY) begin
      nxt_rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = iem_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        iem_pkg::OFF_ENABLE_SET,
        iem_pkg::OFF_ENABLE_CLEAR: begin
          nxt_rdata = mask;
        end
        iem_pkg::OFF_EVENT_FLAGS: begin
          nxt_rdata = EVENT_FLAGS;
        end
        iem_pkg::OFF_EVENT_MASKED: begin
          nxt_rdata = EVENT_FLAGS & {1'b1, mask[30:0]};
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = iem_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= 2'h0;
      irq_ff    <= 1'b0;
      arready_ff <= 1'b1;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      irq_ff    <= irq_req;
      arready_ff <= nxt_arready;
    end
  end

  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY  = wready_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign IRQ_OUT       = irq_ff;

  chk_gate_off: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !mask[iem_pkg::GATE_BIT] |=> !IRQ_OUT)
    else $error("irq raised with gate off");
  chk_irq_follow: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mask[31] && |(EVENT_FLAGS[30:0] & mask[30:0])) |=> IRQ_OUT)
    else $error("irq missing for enabled event");
  chk_irq_cause: assert property (@(posedge SYS_CLK) disable iff (RESET)
    IRQ_OUT |-> $past(mask[31] && |(EVENT_FLAGS[30:0] & mask[30:0])))
    else $error("irq without enabled event");
  chk_soft_irq: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mask[31] && mask[iem_pkg::SOFT_BIT] && EVENT_FLAGS[iem_pkg::SOFT_BIT]) |=> IRQ_OUT)
    else $error("software event did not interrupt");
  chk_maker_irq: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mask[31] && mask[iem_pkg::MAKER_BIT] && EVENT_FLAGS[iem_pkg::MAKER_BIT]) |=> IRQ_OUT)
    else $error("maker event did not interrupt");
  chk_read_mask: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (S_AXI_ARVALID && S_AXI_ARREADY &&
     (S_AXI_ARADDR == iem_pkg::OFF_ENABLE_SET || S_AXI_ARADDR == iem_pkg::OFF_ENABLE_CLEAR))
    |=> S_AXI_RVALID && S_AXI_RDATA == $past(mask))
    else $error("mask read returned wrong value");
  chk_read_reserved: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (S_AXI_ARVALID && S_AXI_ARREADY &&
     (S_AXI_ARADDR == iem_pkg::OFF_ENABLE_SET || S_AXI_ARADDR == iem_pkg::OFF_ENABLE_CLEAR))
    |=> (S_AXI_RDATA & ~iem_pkg::MASK_WRITABLE) == 32'h0000_0000)
    else $error("reserved mask bits read nonzero");
  chk_masked_read: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == iem_pkg::OFF_EVENT_MASKED)
    |=> S_AXI_RDATA == {$past(EVENT_FLAGS[31]), $past(EVENT_FLAGS[30:0] & mask[30:0])})
    else $error("masked event read depends on gate");
  chk_bresp_okay: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (set_we || clr_we) |=> S_AXI_BVALID && S_AXI_BRESP == iem_pkg::RESP_OKAY)
    else $error("mask write not answered okay");
endmodule

// >>> testbench/tb.sv
// register and interrupt bench for the interrupt enable mask
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] event_flags = 0, wdata = 0, rdata, m, e;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, irq_out;
  int          errors = 0, samples_checked = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  iem_top i_iem_top (.SYS_CLK(sys_clk), .RESET(reset), .EVENT_FLAGS(event_flags), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ_OUT(irq_out));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
    logic ta, tw;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    ta = 0;
    tw = 0;
    while (!(ta && tw)) begin
      @(negedge sys_clk);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge sys_clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    do @(negedge sys_clk); while (!bvalid);
    rs = bresp;
    @(posedge sys_clk);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    do @(negedge sys_clk); while (!arready);
    @(posedge sys_clk);
    arvalid <= 0;
    do @(negedge sys_clk); while (!rvalid);
    d = rdata;
    rs = rresp;
    @(posedge sys_clk);
    rready <= 0;
  endtask
  task automatic ev(input logic [31:0] f, input logic x);
    @(posedge sys_clk);
    event_flags <= f;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq", {31'h0, x}, {31'h0, irq_out});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 0;
    rd(8'h88, m, r);
    chk("mask reset", 32'h0000_0000, m);
    wr(8'h88, 32'hFFFF_FFFF, 4'hF, r);
    chk("bresp set", 32'h0, {30'h0, r});
    rd(8'h88, m, r);
    chk("mask via set", 32'hEFFF_83FF, m);
    wr(8'h8C, 32'h0000_FFFF, 4'hF, r);
    rd(8'h8C, m, r);
    chk("mask via clear", 32'hEFFF_0000, m);
    wr(8'h88, 32'hFFFF_FFFF, 4'h1, r);
    rd(8'h88, m, r);
    chk("mask byte lane", 32'hEFFF_00FF, m);
    wr(8'hF0, 32'h0, 4'hF, r);
    chk("bresp unmapped", 32'h2, {30'h0, r});
    rd(8'hF0, m, r);
    chk("rresp unmapped", 32'h2, {30'h0, r});
    $display("test registers done");
    for (int i = 0; i < 31; i++) begin
      e = 32'h1 << i;
      wr(8'h8C, 32'hFFFF_FFFF, 4'hF, r);
      wr(8'h88, 32'h8000_0000 | e, 4'hF, r);
      ev(e, !(i == 28 || (i >= 10 && i <= 14)));
      ev(~e & 32'h7FFF_FFFF, 1'b0);
      wr(8'h8C, 32'h8000_0000, 4'hF, r);
      ev(e, 1'b0);
    end
    $display("test interrupt gating done");
    wr(8'h88, 32'h2000_0005, 4'hF, r);
    ev(32'hA000_0003, 1'b0);
    rd(8'h84, m, r);
    chk("masked events gate off", 32'hA000_0001, m);
    rd(8'h80, m, r);
    chk("raw events", 32'hA000_0003, m);
    wr(8'h88, 32'h8000_0000, 4'hF, r);
    rd(8'h84, m, r);
    chk("masked events gate on", 32'hA000_0001, m);
    ev(32'hA000_0003, 1'b1);
    $display("test masked read done");
    final_report();
  end
endmodule
